// *** hdl/csm_map.vh ***
// Register map, field layout, reset values and timing counts of the cascade setpoint manager.
// Assumes a 10 MHz hclk and word-aligned AHB-Lite accesses.
`ifndef CSM_MAP_VH
`define CSM_MAP_VH
// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define CSM_A_CFG 8'h00
`define CSM_A_SPMIN 8'h04
`define CSM_A_SPMAX 8'h08
`define CSM_A_SPINIT 8'h0C
`define CSM_A_RATES 8'h10
`define CSM_A_FASTDLY 8'h14
`define CSM_A_RMTSCL 8'h18
`define CSM_A_RMTLIM 8'h1C
`define CSM_A_CMD 8'h20
`define CSM_A_ENTRY 8'h24
`define CSM_A_STATUS 8'h28
`define CSM_A_REF 8'h2C
`define CSM_A_PVN 8'h30
`define CSM_A_DROOP 8'h34
// ----------------------------------------------------------------------------
// Configuration bits
// ----------------------------------------------------------------------------
`define CSM_CFG_CASC 0
`define CSM_CFG_RMT 1
`define CSM_CFG_TRACK 2
`define CSM_CFG_DROOP 3
`define CSM_CFG_INV 4
// Command register bits: 0 casc en,1 casc dis,2 rmt en,3 rmt dis,4 raise,5 lower.
`define CSM_CMD_CEN 0
`define CSM_CMD_CDIS 1
`define CSM_CMD_REN 2
`define CSM_CMD_RDIS 3
`define CSM_CMD_RAISE 4
`define CSM_CMD_LOWER 5
// ----------------------------------------------------------------------------
// Reset values and analog thresholds (12-bit mA code, 4 mA = 0x333, 20 mA = 0xFFF)
// ----------------------------------------------------------------------------
`define CSM_RST_SPMAX 16'hFFFF
`define CSM_RST_INIT 16'h8000
`define CSM_RST_RATES 32'h0010_0001
`define CSM_RST_FAST 16'h0064
`define CSM_MA_4 12'h333
`define CSM_MA_20 12'hFFF
`define CSM_MA_LO 12'h199
`define CSM_MA_HI 12'hFFF
`define CSM_MA_SPAN 12'hCCC
`endif

// *** hdl/csm_top.v ***
// Cascade setpoint manager: state reporting, source arbitration and reference ramp.
// Assumes one 10 MHz clock, an AHB-Lite master and synchronous inputs from a sampled ADC.
`timescale 1ns/1ns
`default_nettype none
`include "csm_map.vh"
// Function
// - Report seven cascade states
// - Inhibit cascade on fault, stop, shutdown, unconfigured
// - Load initial setpoint at power-up
// - Normalize PV and setpoint over span
// - Raise/lower ramps at default rate
// - Held command switches to fast rate
// - Raise/lower are level sensitive
// - Entered setpoint clamped, default rate
// - Remote input scaled, clamped, remote rate
// - Priority remote, panel, link one, link two
// - Remote enabled blocks raise, lower and entries
// - Tracking copies PV while disabled
// - No tracking holds last reference
// - Droop subtracts percent of speed reference
// - Optional process input inversion
// - Remote enable follows latest command
// - Contact closed after trip needs reclose
// - Link enable/disable commands act on rising edge
// - Remote out of window alarms, inhibits
// - Cascade and remote speed exclusive
// - Report five remote setpoint states
// - Inhibit remote on fault, stop, shutdown
// - Control needs speed loop and speed
// - Cascade enable contact, latest command wins
module csm_top (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire [15:0] pv_raw,
   input wire pv_fail,
   input wire [11:0] rmt_ma,
   input wire [15:0] speed_ref,
   input wire speed_in_ctrl,
   input wire speed_above_min,
   input wire ctrl_stop,
   input wire shutdown,
   input wire trip_clear,
   input wire casc_contact,
   input wire rmt_contact,
   input wire raise_contact,
   input wire lower_contact,
   input wire [7:0] link1_cmd,
   input wire link1_entry_vld,
   input wire [15:0] link1_entry,
   input wire [7:0] link2_cmd,
   input wire link2_entry_vld,
   input wire [15:0] link2_entry,
   input wire rss_enable_req,
   output reg rss_disable,
   output reg [2:0] casc_state,
   output reg [2:0] rmt_state,
   output reg rmt_alarm,
   output reg [15:0] casc_ref,
   output reg [15:0] pv_norm,
   output reg [15:0] sp_norm
);
   // ------------------------------------------------------------------------
   // State codes
   // ------------------------------------------------------------------------
   localparam [2:0] CS_DIS = 3'h0, CS_EN = 3'h1, CS_ACT = 3'h2, CS_CTL = 3'h3;
   localparam [2:0] CS_ACT_R = 3'h4, CS_CTL_R = 3'h5, CS_INH = 3'h6;
   localparam [2:0] RS_DIS = 3'h0, RS_EN = 3'h1, RS_ACT = 3'h2, RS_CTL = 3'h3, RS_INH = 3'h4;

   function [15:0] clamp16;
      input [15:0] v;
      input [15:0] lo;
      input [15:0] hi;
      begin
         clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
      end
   endfunction

   function [15:0] norm16;
      input [15:0] v;
      input [15:0] lo;
      input [15:0] hi;
      reg [15:0] c;
      reg [31:0] q;
      begin
         c = clamp16(v, lo, hi);
         q = (hi > lo) ? ({c - lo, 16'h0000} - {16'h0000, c - lo}) / {16'h0000, hi - lo} : 32'h0000_0000;
         norm16 = q[15:0];
      end
   endfunction

   function [15:0] step16;
      input [15:0] cur;
      input [15:0] tgt;
      input [15:0] inc;
      begin
         if (cur < tgt)
            step16 = (tgt - cur > inc) ? cur + inc : tgt;
         else
            step16 = (cur - tgt > inc) ? cur - inc : tgt;
      end
   endfunction

   // ------------------------------------------------------------------------
   // Contact synchronisers
   // ------------------------------------------------------------------------
   reg [3:0] s1_r, s2_r, s3_r, cont_r;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_r <= 4'h0;
         s2_r <= 4'h0;
         s3_r <= 4'h0;
         cont_r <= 4'h0;
      end else begin
         s1_r <= {lower_contact, raise_contact, rmt_contact, casc_contact};
         s2_r <= s1_r;
         s3_r <= s2_r;
         cont_r <= (s2_r & s3_r) | (~s2_r & ~s3_r & 4'h0) | (cont_r & (s2_r ^ s3_r));
      end
   end
   wire cont_casc = cont_r[0];
   wire cont_rmt = cont_r[1];

   // ------------------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------------------
   reg [7:0] cfg_r, cmd_r, l1_r, l2_r;
   reg [15:0] spmin_r, spmax_r, spinit_r, fastdly_r, droop_pct_r;
   reg [31:0] rates_r, rmtscl_r, rmtlim_r;
   reg [15:0] panel_entry_r;
   reg panel_entry_vld_r;
   reg dph_r, dwr_r;
   reg [7:0] da_r;
   wire acc = hsel & hready & htrans[1];
   wire wr = dph_r & dwr_r;
   wire [15:0] def_rate = rates_r[15:0];
   wire [15:0] fast_rate = rates_r[31:16];
   wire [15:0] rmt_rate = rmtscl_r[31:16];

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph_r <= 1'b0;
         dwr_r <= 1'b0;
         da_r <= 8'h00;
         cfg_r <= 8'h00;
         cmd_r <= 8'h00;
         spmin_r <= 16'h0000;
         spmax_r <= `CSM_RST_SPMAX;
         spinit_r <= `CSM_RST_INIT;
         rates_r <= `CSM_RST_RATES;
         fastdly_r <= `CSM_RST_FAST;
         rmtscl_r <= `CSM_RST_RATES;
         rmtlim_r <= {`CSM_RST_SPMAX, 16'h0000};
         droop_pct_r <= 16'h0000;
         panel_entry_r <= 16'h0000;
         panel_entry_vld_r <= 1'b0;
      end else begin
         dph_r <= acc;
         dwr_r <= hwrite;
         da_r <= haddr[7:0];
         panel_entry_vld_r <= 1'b0;
         if (wr) begin
            case (da_r)
               `CSM_A_CFG: cfg_r <= hwdata[7:0];
               `CSM_A_SPMIN: spmin_r <= hwdata[15:0];
               `CSM_A_SPMAX: spmax_r <= hwdata[15:0];
               `CSM_A_SPINIT: spinit_r <= hwdata[15:0];
               `CSM_A_RATES: rates_r <= hwdata;
               `CSM_A_FASTDLY: fastdly_r <= hwdata[15:0];
               `CSM_A_RMTSCL: rmtscl_r <= hwdata;
               `CSM_A_RMTLIM: rmtlim_r <= hwdata;
               `CSM_A_CMD: cmd_r <= hwdata[7:0];
               `CSM_A_ENTRY: begin
                  panel_entry_r <= hwdata[15:0];
                  panel_entry_vld_r <= 1'b1;
               end
               `CSM_A_DROOP: droop_pct_r <= hwdata[15:0];
               default: ;
            endcase
         end
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         case (haddr[7:0])
            `CSM_A_CFG: hrdata <= {24'h000000, cfg_r};
            `CSM_A_SPMIN: hrdata <= {16'h0000, spmin_r};
            `CSM_A_SPMAX: hrdata <= {16'h0000, spmax_r};
            `CSM_A_SPINIT: hrdata <= {16'h0000, spinit_r};
            `CSM_A_RATES: hrdata <= rates_r;
            `CSM_A_FASTDLY: hrdata <= {16'h0000, fastdly_r};
            `CSM_A_RMTSCL: hrdata <= rmtscl_r;
            `CSM_A_RMTLIM: hrdata <= rmtlim_r;
            `CSM_A_CMD: hrdata <= {24'h000000, cmd_r};
            `CSM_A_STATUS: hrdata <= {24'h000000, rmt_alarm, rmt_state, 1'b0, casc_state};
            `CSM_A_REF: hrdata <= {16'h0000, casc_ref};
            `CSM_A_PVN: hrdata <= {sp_norm, pv_norm};
            `CSM_A_DROOP: hrdata <= {16'h0000, droop_pct_r};
            default: hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // ------------------------------------------------------------------------
   // Command edges
   // ------------------------------------------------------------------------
   reg [7:0] l1p_r, l2p_r, cmdp_r;
   reg [1:0] contp_r;
   reg casc_arm_r, rmt_arm_r;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         l1p_r <= 8'h00;
         l2p_r <= 8'h00;
         cmdp_r <= 8'h00;
         contp_r <= 2'b00;
         casc_arm_r <= 1'b0;
         rmt_arm_r <= 1'b0;
      end else begin
         l1p_r <= link1_cmd;
         l2p_r <= link2_cmd;
         cmdp_r <= cmd_r;
         contp_r <= {cont_rmt, cont_casc};
         if (trip_clear) begin
            casc_arm_r <= 1'b0;
            rmt_arm_r <= 1'b0;
         end else begin
            casc_arm_r <= casc_arm_r | ~cont_casc;
            rmt_arm_r <= rmt_arm_r | ~cont_rmt;
         end
      end
   end
   wire [7:0] rise = (link1_cmd & ~l1p_r) | (link2_cmd & ~l2p_r) | (cmd_r & ~cmdp_r);
   wire cen_cont = cont_casc & ~contp_r[0] & casc_arm_r;
   wire cdis_cont = ~cont_casc & contp_r[0];
   wire ren_cont = cont_rmt & ~contp_r[1] & rmt_arm_r;
   wire rdis_cont = ~cont_rmt & contp_r[1];

   // ------------------------------------------------------------------------
   // Enables and states
   // ------------------------------------------------------------------------
   wire rmt_bad = (rmt_ma < `CSM_MA_LO) || (rmt_ma > `CSM_MA_HI) || (rmt_ma == 12'h000);
   wire casc_inh = pv_fail | ctrl_stop | shutdown | ~cfg_r[`CSM_CFG_CASC];
   wire rmt_inh = rmt_bad | pv_fail | ctrl_stop | shutdown | ~cfg_r[`CSM_CFG_RMT];
   reg casc_en_r, rmt_en_r;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         casc_en_r <= 1'b0;
         rmt_en_r <= 1'b0;
         rss_disable <= 1'b0;
         rmt_alarm <= 1'b0;
      end else begin
         rmt_alarm <= rmt_bad & cfg_r[`CSM_CFG_RMT];
         rss_disable <= rise[`CSM_CMD_CEN] | cen_cont;
         if (casc_inh || rss_enable_req)
            casc_en_r <= 1'b0;
         else if (rise[`CSM_CMD_CEN] || cen_cont)
            casc_en_r <= 1'b1;
         else if (rise[`CSM_CMD_CDIS] || cdis_cont)
            casc_en_r <= 1'b0;
         if (rmt_inh)
            rmt_en_r <= 1'b0;
         else if (rise[`CSM_CMD_REN] || ren_cont)
            rmt_en_r <= 1'b1;
         else if (rise[`CSM_CMD_RDIS] || rdis_cont)
            rmt_en_r <= 1'b0;
      end
   end
   wire casc_go = casc_en_r & speed_above_min;
   wire in_ctl = casc_go & speed_in_ctrl;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         casc_state <= CS_DIS;
         rmt_state <= RS_DIS;
      end else begin
         if (casc_inh)
            casc_state <= CS_INH;
         else if (!casc_en_r)
            casc_state <= CS_DIS;
         else if (!casc_go)
            casc_state <= CS_EN;
         else
            casc_state <= in_ctl ? (rmt_en_r ? CS_CTL_R : CS_CTL) : (rmt_en_r ? CS_ACT_R : CS_ACT);
         if (rmt_inh)
            rmt_state <= RS_INH;
         else if (!rmt_en_r)
            rmt_state <= RS_DIS;
         else if (!casc_go || casc_inh)
            rmt_state <= RS_EN;
         else
            rmt_state <= in_ctl ? RS_CTL : RS_ACT;
      end
   end

   // ------------------------------------------------------------------------
   // Remote scaling and process input
   // ------------------------------------------------------------------------
   reg [11:0] ma_c;
   reg [31:0] rprod;
   reg [15:0] rmt_eng;
   reg [15:0] pv_in;
   always @* begin
      ma_c = (rmt_ma < `CSM_MA_4) ? `CSM_MA_4 : rmt_ma;
      rprod = {20'h00000, ma_c - `CSM_MA_4} * {16'h0000, rmtscl_r[15:0]} / {20'h00000, `CSM_MA_SPAN};
      rmt_eng = clamp16(rprod[15:0], rmtlim_r[15:0], rmtlim_r[31:16]);
      pv_in = cfg_r[`CSM_CFG_INV] ? ~pv_raw : pv_raw;
   end

   // ------------------------------------------------------------------------
   // Reference ramp
   // ------------------------------------------------------------------------
   reg [15:0] tgt_r, hold_r;
   reg tgt_vld_r, init_r;
   wire up = rise[`CSM_CMD_RAISE] | link1_cmd[`CSM_CMD_RAISE] | link2_cmd[`CSM_CMD_RAISE] |
             cmd_r[`CSM_CMD_RAISE] | cont_r[2];
   wire dn = link1_cmd[`CSM_CMD_LOWER] | link2_cmd[`CSM_CMD_LOWER] | cmd_r[`CSM_CMD_LOWER] | cont_r[3];
   wire [15:0] rl_rate = (hold_r >= fastdly_r) ? fast_rate : def_rate;
   reg [15:0] ref_nxt;
   always @* begin
      ref_nxt = casc_ref;
      if (cfg_r[`CSM_CFG_TRACK] && !casc_en_r)
         ref_nxt = clamp16(pv_in, spmin_r, spmax_r);
      else if (rmt_en_r)
         ref_nxt = step16(casc_ref, rmt_eng, rmt_rate);
      else if (up ^ dn)
         ref_nxt = up ? step16(casc_ref, spmax_r, rl_rate) : step16(casc_ref, spmin_r, rl_rate);
      else if (tgt_vld_r)
         ref_nxt = step16(casc_ref, tgt_r, def_rate);
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         init_r <= 1'b0;
         casc_ref <= 16'h0000;
         tgt_r <= 16'h0000;
         tgt_vld_r <= 1'b0;
         hold_r <= 16'h0000;
         pv_norm <= 16'h0000;
         sp_norm <= 16'h0000;
      end else begin
         init_r <= 1'b1;
         if (!init_r)
            casc_ref <= spinit_r;
         else
            casc_ref <= ref_nxt;
         hold_r <= ((up ^ dn) && hold_r != 16'hFFFF) ? hold_r + 16'h0001 : ((up ^ dn) ? hold_r : 16'h0000);
         if (rmt_en_r || (up ^ dn) || (cfg_r[`CSM_CFG_TRACK] && !casc_en_r) || casc_ref == tgt_r)
            tgt_vld_r <= 1'b0;
         if (!rmt_en_r) begin
            if (panel_entry_vld_r) begin
               tgt_r <= clamp16(panel_entry_r, spmin_r, spmax_r);
               tgt_vld_r <= 1'b1;
            end else if (link1_entry_vld) begin
               tgt_r <= clamp16(link1_entry, spmin_r, spmax_r);
               tgt_vld_r <= 1'b1;
            end else if (link2_entry_vld) begin
               tgt_r <= clamp16(link2_entry, spmin_r, spmax_r);
               tgt_vld_r <= 1'b1;
            end
         end
         pv_norm <= droop_sub(norm16(pv_in, spmin_r, spmax_r));
         sp_norm <= norm16(casc_ref, spmin_r, spmax_r);
      end
   end

   function [15:0] droop_sub;
      input [15:0] pn;
      reg [31:0] d;
      begin
         d = ({16'h0000, speed_ref} * {16'h0000, droop_pct_r}) >> 16;
         droop_sub = (!cfg_r[`CSM_CFG_DROOP]) ? pn : ((pn > d[15:0]) ? pn - d[15:0] : 16'h0000);
      end
   endfunction
endmodule
`default_nettype wire

// *** sim/csm_far.sv ***
// Far-side model: process transmitter, speed loop and remote current source.
// Assumes the bench sets the process value, the remote current and the speed loop flags.
`timescale 1ns/1ns
`default_nettype none
module csm_far (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [11:0] ma_set,
   input wire logic spd_ok,
   input wire logic min_ok,
   input wire logic [15:0] pv_set,
   output logic [15:0] pv_raw,
   output logic [15:0] speed_ref,
   output logic [11:0] rmt_ma,
   output logic speed_in_ctrl,
   output logic speed_above_min
);
   integer seed = 72;
   // ----
   // Process values move every cycle, just after the edge
   // ----
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pv_raw <= 16'h0000;
         speed_ref <= 16'h0000;
         rmt_ma <= 12'h999;
         speed_in_ctrl <= 1'b0;
         speed_above_min <= 1'b0;
      end else begin
         pv_raw <= pv_set;
         speed_ref <= 16'($random(seed));
         rmt_ma <= ma_set;
         speed_in_ctrl <= spd_ok;
         speed_above_min <= min_ok;
      end
   end
endmodule
`default_nettype wire

// *** sim/csm_top_props.sv ***
// Checker of the cascade setpoint manager's state and bus outputs.
// Assumes it is bound to csm_top and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module csm_top_props (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic pv_fail,
   input wire logic [11:0] rmt_ma,
   input wire logic speed_in_ctrl,
   input wire logic ctrl_stop,
   input wire logic shutdown,
   input wire logic rss_enable_req,
   input wire logic rss_disable,
   input wire logic [2:0] casc_state,
   input wire logic [2:0] rmt_state,
   input wire logic rmt_alarm
);
   // ----
   // Properties
   // ----
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   AST_BUS_OKAY: assert property (hreadyout && !hresp)
      else $error("Bus answer was not ready and okay.");
   AST_CASC_INHIBIT: assert property ((pv_fail || ctrl_stop || shutdown) [*3] |-> ##[0:2] casc_state == 3'h6)
      else $error("Cascade not inhibited under a fault.");
   AST_RMT_INHIBIT: assert property ((pv_fail || ctrl_stop || shutdown) [*3] |-> ##[0:2] rmt_state == 3'h4)
      else $error("Remote setpoint not inhibited under a fault.");
   AST_WINDOW_ALARM: assert property ((rmt_ma < 12'h199) [*3] |-> ##[0:2] rmt_alarm)
      else $error("No alarm for a remote current out of window.");
   AST_RSS_EXCL: assert property (rss_enable_req [*3] |-> ##[0:2] (casc_state == 3'h0 || casc_state == 3'h6))
      else $error("Cascade stays on beside remote speed setpoint.");
   AST_RSS_PULSE: assert property (rss_disable |=> !rss_disable)
      else $error("Remote speed disable is longer than one cycle.");
   AST_CTL_SPEED: assert property (!speed_in_ctrl [*3] |-> ##[0:2] casc_state != 3'h3 && casc_state != 3'h5)
      else $error("Cascade in control without the speed loop.");
   AST_STATE_CODE: assert property (casc_state != 3'h7 && rmt_state <= 3'h4)
      else $error("State code outside its list.");
   AST_RMT_CTL: assert property (rmt_state == 3'h3 |-> casc_state == 3'h5)
      else $error("Remote in control while cascade is not.");
endmodule
bind csm_top csm_top_props u_props (.hclk, .hresetn, .hreadyout, .hresp, .pv_fail, .rmt_ma, .speed_in_ctrl,
   .ctrl_stop, .shutdown, .rss_enable_req, .rss_disable, .casc_state, .rmt_state, .rmt_alarm);
`default_nettype wire

// *** sim/csm_top_tb_top.sv ***
// Self-checking bench of the cascade setpoint manager over its AHB-Lite port.
// Assumes csm_top, csm_far and the checker are compiled before it.
`timescale 1ns/1ns
`default_nettype none
`include "csm_map.vh"
module csm_top_tb_top;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rss_disable, rmt_alarm, dp_r;
   logic speed_in_ctrl, speed_above_min, spd_ok, raise_c, lower_c, rmt_c, rss_req, l2_vld, min_ok, casc_c, trip_c;
   logic [31:0] haddr, hwdata, hrdata, last_rd;
   logic [1:0] htrans;
   logic [2:0] hsize, casc_state, rmt_state, inh;
   logic [15:0] pv_raw, speed_ref, casc_ref, pv_norm, sp_norm, link2_entry, pv_set;
   logic [11:0] rmt_ma, ma_set;
   logic [7:0] link1_cmd, rb;
   logic [31:0] exp_q[$];
   logic [31:0] msk_q[$];
   integer err_total = 0, check_count = 0, cyc = 0, seed = 72, i, rss_n = 0;
   csm_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
      .hreadyout, .hresp, .pv_raw, .pv_fail(inh[2]), .rmt_ma, .speed_ref, .speed_in_ctrl, .speed_above_min,
      .ctrl_stop(inh[1]), .shutdown(inh[0]), .trip_clear(trip_c), .casc_contact(casc_c), .rmt_contact(rmt_c),
      .raise_contact(raise_c), .lower_contact(lower_c), .link1_cmd, .link1_entry_vld(1'b0),
      .link1_entry(16'h0000), .link2_cmd(8'h00), .link2_entry_vld(l2_vld), .link2_entry,
      .rss_enable_req(rss_req), .rss_disable, .casc_state, .rmt_state, .rmt_alarm, .casc_ref, .pv_norm, .sp_norm);
   csm_far far (.hclk, .hresetn, .ma_set, .spd_ok, .min_ok, .pv_set, .pv_raw, .speed_ref, .rmt_ma, .speed_in_ctrl,
      .speed_above_min);
   // ----
   // Tasks
   // ----
   task automatic give_verdict;
      $display("Checks %0d, errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h000000, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      last_rd = hrdata;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      bus(a, 1'b0, 32'h0000_0000);
   endtask
   task automatic cmp_rd(input logic [31:0] e, input logic [31:0] m);
      check_count++;
      if ((hrdata & m) !== (e & m)) begin
         err_total++;
         $display("Error at %0t: read %h expected %h", $time, hrdata & m, e & m);
      end
   endtask
   task automatic chk_ref(input logic [15:0] g, input logic [15:0] lo, input logic [15:0] hi);
      check_count++;
      if ((g >= lo && g <= hi && g[7:0] == 8'h00) !== 1'b1) begin
         err_total++;
         $display("Error at %0t: reference %h expected %h to %h", $time, g, lo, hi);
      end
   endtask
   task automatic chk_cnt(input integer g, input integer e);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("Error at %0t: count %h expected %h", $time, g, e);
      end
   endtask
   task automatic ref_in(input logic [15:0] lo, input logic [15:0] hi);
      repeat (5) @(posedge hclk);
      rd(`CSM_A_REF, 32'h0000_0000, 32'h0000_0000);
      chk_ref(last_rd[15:0], lo, hi);
   endtask
   task automatic st_is(input logic [7:0] e, input logic [7:0] m);
      repeat (5) @(posedge hclk);
      rd(`CSM_A_STATUS, {24'h000000, e}, {24'h000000, m});
   endtask
   // ----
   // Read watcher and cycle limit
   // ----
   always @(posedge hclk) begin
      if (dp_r && hreadyout) begin
         cmp_rd(exp_q.pop_front(), msk_q.pop_front());
      end
      dp_r <= hresetn && hsel && htrans[1] && !hwrite && hreadyout;
      rss_n += (rss_disable === 1'b1);
      cyc++;
      if (cyc == 10000) begin
         err_total++;
         give_verdict();
      end
   end
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   // ----
   // Main sequence
   // ----
   initial begin
      {hresetn, hsel, hwrite, raise_c, lower_c, rmt_c, rss_req, l2_vld, casc_c, trip_c} = 10'h000;
      {haddr, hwdata, htrans, inh, link1_cmd, link2_entry, pv_set} = '0;
      {hsize, ma_set, spd_ok, min_ok} = {3'b010, 12'h999, 1'b1, 1'b1};
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      rd(`CSM_A_REF, {16'h0000, `CSM_RST_INIT}, 32'hFFFF_FFFF);
      bus(`CSM_A_CFG, 1'b1, 32'h0000_0003);
      bus(`CSM_A_SPMIN, 1'b1, 32'h0000_1000);
      bus(`CSM_A_SPMAX, 1'b1, 32'h0000_F000);
      bus(`CSM_A_RATES, 1'b1, 32'h0400_0100);
      bus(`CSM_A_FASTDLY, 1'b1, 32'h0000_001E);
      bus(`CSM_A_RMTSCL, 1'b1, 32'h0200_9000);
      bus(`CSM_A_RMTLIM, 1'b1, 32'h7000_2000);
      rd(`CSM_A_CFG, 32'h0000_0003, 32'hFFFF_FFFF);
      rd(8'h3C, 32'h0000_0000, 32'hFFFF_FFFF);
      raise_c <= 1'b1;
      repeat (20) @(posedge hclk);
      raise_c <= 1'b0;
      ref_in(16'h8100, 16'h9400);
      raise_c <= 1'b1;
      repeat (80) @(posedge hclk);
      raise_c <= 1'b0;
      ref_in(16'hF000, 16'hF000);
      lower_c <= 1'b1;
      repeat (10) @(posedge hclk);
      lower_c <= 1'b0;
      ref_in(16'hE600, 16'hEF00);
      ref_in(last_rd[15:0], last_rd[15:0]);
      rb = 8'($random(seed));
      link2_entry <= {8'h10 + {1'b0, rb[6:0]}, 8'h00};
      l2_vld <= 1'b1;
      @(posedge hclk);
      l2_vld <= 1'b0;
      repeat (250) @(posedge hclk);
      ref_in(link2_entry, link2_entry);
      bus(`CSM_A_ENTRY, 1'b1, 32'h0000_0010);
      repeat (250) @(posedge hclk);
      ref_in(16'h1000, 16'h1000);
      link1_cmd <= 8'h01;
      st_is(8'h03, 8'h07);
      bus(`CSM_A_CMD, 1'b1, 32'h0000_0002);
      bus(`CSM_A_CMD, 1'b1, 32'h0000_0000);
      st_is(8'h00, 8'h07);
      link1_cmd <= 8'h00;
      @(posedge hclk);
      link1_cmd <= 8'h01;
      st_is(8'h03, 8'h07);
      spd_ok <= 1'b0;
      st_is(8'h02, 8'h07);
      min_ok <= 1'b0;
      st_is(8'h01, 8'h07);
      spd_ok <= 1'b1;
      min_ok <= 1'b1;
      ma_set <= 12'hFFF;
      rmt_c <= 1'b1;
      repeat (100) @(posedge hclk);
      ref_in(16'h7000, 16'h7000);
      st_is(8'h35, 8'hF7);
      bus(`CSM_A_ENTRY, 1'b1, 32'h0000_4000);
      repeat (40) @(posedge hclk);
      ref_in(16'h7000, 16'h7000);
      ma_set <= `CSM_MA_4;
      repeat (100) @(posedge hclk);
      ref_in(16'h2000, 16'h2000);
      ma_set <= 12'h100;
      st_is(8'hC0, 8'hF0);
      ma_set <= 12'h999;
      st_is(8'h00, 8'hF0);
      rss_req <= 1'b1;
      st_is(8'h00, 8'h07);
      rss_req <= 1'b0;
      bus(`CSM_A_CMD, 1'b1, 32'h0000_0001);
      bus(`CSM_A_CMD, 1'b1, 32'h0000_0000);
      st_is(8'h03, 8'h07);
      for (i = 0; i < 3; i++) begin
         inh <= 3'(3'b001 << i);
         st_is(8'h46, 8'h77);
         inh <= 3'b000;
         @(posedge hclk);
      end
      casc_c <= 1'b1;
      st_is(8'h03, 8'h07);
      casc_c <= 1'b0;
      st_is(8'h00, 8'h07);
      trip_c <= 1'b1;
      @(posedge hclk);
      trip_c <= 1'b0;
      st_is(8'h00, 8'h70);
      rmt_c <= 1'b0;
      repeat (6) @(posedge hclk);
      rmt_c <= 1'b1;
      st_is(8'h10, 8'h70);
      pv_set <= 16'h3400;
      bus(`CSM_A_CFG, 1'b1, 32'h0000_0007);
      ref_in(16'h3400, 16'h3400);
      rd(`CSM_A_PVN, 32'h2924_2924, 32'hFFFF_FFFF);
      pv_set <= 16'h54FF;
      bus(`CSM_A_CFG, 1'b1, 32'h0000_0017);
      ref_in(16'hAB00, 16'hAB00);
      chk_cnt(rss_n, 4);
      give_verdict();
   end
endmodule
`default_nettype wire
